// >>> core/sf_fir_core.sv
// Purpose: bit-serial distributed arithmetic FIR filter with APB status
// Assumes: sample source and cascade neighbours run on pclk
// Notes:   coefficients are constants fixed when the block is built
`include "sf_defs.svh"

module sf_fir_core (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire sf_pkg::sf_addr_t   paddr,
  input  wire sf_pkg::sf_word_t   pwdata,
  output sf_pkg::sf_word_t        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               sample_strobe,
  input  wire sf_pkg::sf_sample_t sample_in,
  input  wire logic               fwd_serial_in,
  input  wire logic               rev_serial_in,
  output logic                    sample_request_flag,
  output logic                    result_valid_flag,
  output sf_pkg::sf_result_t      filter_output_word,
  output logic                    fwd_serial_out,
  output logic                    rev_serial_out
);
  import sf_pkg::*;

  // ****************************************************************
  // configuration
  // ****************************************************************
  localparam int N    = `SF_SAMPLE_W;
  localparam int T    = `SF_TAPS;
  localparam int NC   = `SF_NUM_COEF;
  localparam int FW   = `SF_FULL_W;
  localparam int OW   = `SF_OUT_W;
  localparam bit SYM  = `SF_SYMMETRIC;
  localparam bit SGN  = `SF_SIGNED;
  localparam bit CASC = `SF_CASCADE;
  localparam bit ASYM = SYM && `SF_ANTISYM;
  localparam int H    = T / 2;
  localparam int NP   = SYM ? H : T;
  localparam int NFB  = SYM ? H : T - 1;
  localparam int NRB  = SYM ? H : 1;
  // bit periods per sample depend on width and symmetry alone
  localparam int P    = SYM ? N + 1 : N;
  localparam bit NEG_LAST = SGN || ASYM;

  // pipeline depth after the serial phase
  localparam int LAT = SYM ?
    ((T <= `SF_LAT_SY_T1) ? `SF_LAT_SY_A :
     (T <= `SF_LAT_SY_T2) ? `SF_LAT_SY_B : `SF_LAT_SY_C) :
    ((T <= `SF_LAT_NS_T1) ? `SF_LAT_NS_A :
     (T <= `SF_LAT_NS_T2) ? `SF_LAT_NS_B : `SF_LAT_NS_C);
  localparam int NPIPE = LAT - 2;

  localparam sf_cnt_t LAST_CNT = sf_cnt_t'(P - 1);
  localparam sf_cnt_t RFD_CNT  = sf_cnt_t'(P - 2);
  localparam sf_cnt_t MSB_CNT  = sf_cnt_t'(N - 1);

  // out-of-range builds are flagged in status rather than silently run
  localparam bit CFG_OK =
    (N >= `SF_SAMPLE_MIN) && (N <= `SF_SAMPLE_MAX) &&
    (`SF_COEF_W >= `SF_COEF_MIN) && (`SF_COEF_W <= `SF_COEF_MAX) &&
    (OW >= `SF_OUT_MIN) && (OW <= `SF_OUT_MAX) && (OW <= FW) &&
    (T >= `SF_TAPS_MIN) &&
    (T <= (SYM ? `SF_TAPS_SY_MAX : `SF_TAPS_NS_MAX)) &&
    (!`SF_ANTISYM || SYM) && (NC == NP) && (!SYM || T % 2 == 0);

  // ****************************************************************
  // coefficient tables
  // ****************************************************************
  // symmetric build: one entry per tap pair
  localparam logic signed [`SF_COEF_W-1:0] COEF_ROM [NC] =
    '{8'sh01, 8'shF8, 8'sh0C};

  // smallest signed width holding every stored coefficient
  function automatic int rom_width();
    int w;
    int v;
    w = 2;
    for (int i = 0; i < NC; i++) begin
      v = int'(COEF_ROM[i]);
      while ((v < -(1 << (w - 1))) || (v >= (1 << (w - 1)))) w++;
    end
    return w;
  endfunction

  localparam int CW = `SF_TRIM ? rom_width() : `SF_COEF_W;

  // ****************************************************************
  // sequencing signals
  // ****************************************************************
  sf_state_t st_q;
  sf_cnt_t   cnt_q;
  logic      rfd_q;
  logic      done_q;
  logic      srst;
  logic      take;
  logic      shift_en;
  logic      ext_cyc;
  logic      proc_en;
  logic      last_bit;

  sf_sample_t           p2s_q;
  logic [NFB*N-1:0]     fwd_q;
  logic [NRB*N-1:0]     rev_q;
  logic                 ser_in;
  logic                 rev_in;
  logic [NP-1:0]        lo_bit;
  logic [NP-1:0]        hi_bit;
  logic [NP-1:0]        pbit;
  logic [NP-1:0]        carry_q;
  logic [NP-1:0]        lo_ext_q;
  logic [NP-1:0]        hi_ext_q;
  logic signed [CW-1:0] lut_w [NP];

  logic signed [FW-1:0] term;
  logic signed [FW-1:0] wterm;
  logic signed [FW-1:0] acc_q;
  logic signed [FW-1:0] acc_d;
  logic [FW-1:0]        pipe_q [NPIPE];
  logic [NPIPE-1:0]     pv_q;

  sf_word_t ctrl_q;
  sf_word_t result_q;
  sf_word_t count_q;

  assign srst     = ctrl_q[`SF_CTRL_SRST];
  // a strobe while the flag is low would corrupt the shift, so drop it
  assign take     = sample_strobe && rfd_q && !srst;
  assign shift_en = (st_q == SF_SHIFT);
  assign ext_cyc  = (st_q == SF_EXT);
  assign proc_en  = shift_en || ext_cyc;
  assign last_bit = proc_en && (cnt_q == LAST_CNT);

  // cascade sections skip the local converter
  assign ser_in = CASC ? fwd_serial_in : p2s_q[0];
  assign rev_in = CASC ? rev_serial_in : fwd_q[0];

  // ****************************************************************
  // bit sequencer
  // ****************************************************************
  // state advances once per bit period, all on the rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= SF_IDLE;
      cnt_q <= '0;
    end else if (srst) begin
      st_q  <= SF_IDLE;
      cnt_q <= '0;
    end else if (take) begin
      st_q  <= SF_SHIFT;
      cnt_q <= '0;
    end else begin
      case (st_q)
        SF_IDLE: begin
          cnt_q <= '0;
        end
        SF_SHIFT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == MSB_CNT) begin
            st_q <= SYM ? SF_EXT : SF_IDLE;
          end
        end
        SF_EXT: begin
          st_q <= SF_IDLE;
        end
        default: begin
          st_q  <= SF_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // request flag: low after a take, high again during the last bit period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfd_q <= 1'b1;
    end else if (srst) begin
      rfd_q <= 1'b1;
    end else if (take) begin
      rfd_q <= 1'b0;
    end else if (proc_en && cnt_q == RFD_CNT) begin
      rfd_q <= 1'b1;
    end
  end

  // ****************************************************************
  // serial data path
  // ****************************************************************
  // load wins over shift: the old last bit is consumed on that edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2s_q <= '0;
    end else if (take) begin
      p2s_q <= sample_in;
    end else if (shift_en) begin
      p2s_q <= {1'b0, p2s_q[N-1:1]};
    end
  end

  // time-skew buffers hold still during the symmetric extension bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q <= '0;
      rev_q <= '0;
    end else if (shift_en) begin
      fwd_q <= {ser_in, fwd_q[NFB*N-1:1]};
      rev_q <= {rev_in, rev_q[NRB*N-1:1]};
    end
  end

  // per tap (or tap pair): bit taps, serial pre-adder, trimmed ROM word
  for (genvar k = 0; k < NP; k++) begin : g_tap
    logic a_b;
    logic b_b;
    logic cin;

    // a sample is seen by the sum only as it leaves a buffer
    if (k == 0) begin : g_lo0
      assign lo_bit[k] = ser_in;
    end else begin : g_lon
      assign lo_bit[k] = fwd_q[(NFB-k)*N];
    end
    if (!SYM) begin : g_nohi
      assign hi_bit[k] = 1'b0;
    end else if (k == H - 1) begin : g_hi0
      assign hi_bit[k] = rev_in;
    end else begin : g_hin
      assign hi_bit[k] = rev_q[(NRB-H+1+k)*N];
    end

    // mirrored tap shares the coefficient, subtracted when anti-symmetric
    assign a_b = ext_cyc ? lo_ext_q[k] : lo_bit[k];
    assign b_b = (ext_cyc ? hi_ext_q[k] : hi_bit[k]) ^ ASYM;
    assign cin = (cnt_q == '0) ? ASYM : carry_q[k];
    assign pbit[k] = SYM ? (a_b ^ b_b ^ cin) : lo_bit[k];
    assign lut_w[k] = COEF_ROM[k][CW-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        carry_q[k]  <= 1'b0;
        lo_ext_q[k] <= 1'b0;
        hi_ext_q[k] <= 1'b0;
      end else begin
        if (proc_en) begin
          carry_q[k] <= (a_b & b_b) | (a_b & cin) | (b_b & cin);
        end
        // sign bits kept for the extra symmetric bit period
        if (shift_en && cnt_q == MSB_CNT) begin
          lo_ext_q[k] <= SGN & lo_bit[k];
          hi_ext_q[k] <= SGN & hi_bit[k];
        end
      end
    end
  end

  // ****************************************************************
  // distributed arithmetic accumulation
  // ****************************************************************
  // one bit-slice of all taps summed, weighted by its bit position
  always_comb begin
    term = '0;
    for (int i = 0; i < NP; i++) begin
      if (pbit[i]) begin
        term = term + FW'(lut_w[i]);
      end
    end
    wterm = term <<< cnt_q;
    // top bit of a two's complement slice carries negative weight
    acc_d = ((cnt_q == '0) ? '0 : acc_q) +
            ((last_bit && NEG_LAST) ? -wterm : wterm);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q  <= '0;
      done_q <= 1'b0;
    end else begin
      if (proc_en) begin
        acc_q <= acc_d;
      end
      done_q <= last_bit && !srst;
    end
  end

  // ****************************************************************
  // lookup and adder tree latency, output register
  // ****************************************************************
  for (genvar s = 0; s < NPIPE; s++) begin : g_pipe
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pipe_q[s] <= '0;
        pv_q[s]   <= 1'b0;
      end else if (srst) begin
        pv_q[s] <= 1'b0;
      end else if (s == 0) begin
        pipe_q[s] <= acc_q;
        pv_q[s]   <= done_q;
      end else begin
        // index clamped so the first stage never names a stage below zero
        pipe_q[s] <= pipe_q[(s > 0) ? s - 1 : 0];
        pv_q[s]   <= pv_q[(s > 0) ? s - 1 : 0];
      end
    end
  end

  // result word moves with its valid pulse, or alone when soft reset suppresses that pulse; stable while valid is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_valid_flag  <= 1'b0;
      filter_output_word <= '0;
    end else begin
      result_valid_flag <= pv_q[NPIPE-1] && !srst;
      if (pv_q[NPIPE-1]) begin
        filter_output_word <= pipe_q[NPIPE-1][FW-1 -: OW];
      end
    end
  end

  assign sample_request_flag = rfd_q;
  assign fwd_serial_out      = fwd_q[0];
  assign rev_serial_out      = rev_q[0];

  // ****************************************************************
  // software view
  // ****************************************************************
  // last result and count of results, for polling without handshakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
      count_q  <= '0;
    end else if (srst) begin
      count_q <= '0;
    end else if (result_valid_flag) begin
      result_q <= 32'(filter_output_word);
      count_q  <= count_q + 32'h00000001;
    end
  end

  // control write happens at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SF_CTRL_RST;
    end else if (psel && penable && pready && pwrite && !pslverr &&
                 paddr == `SF_REG_CTRL) begin
      ctrl_q <= pwdata & `SF_CTRL_MASK;
    end
  end

  // one wait-free access: answer prepared in setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= '0;
      case (paddr)
        `SF_REG_CTRL: begin
          prdata <= ctrl_q;
        end
        `SF_REG_STATUS: begin
          prdata[`SF_ST_REQ]    <= rfd_q;
          prdata[`SF_ST_BUSY]   <= proc_en;
          prdata[`SF_ST_CFG_OK] <= CFG_OK;
          prdata[`SF_ST_SRST]   <= srst;
        end
        `SF_REG_RESULT: begin
          prdata <= result_q;
        end
        `SF_REG_COUNT: begin
          prdata <= count_q;
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // sf_fir_core

// >>> core/sf_defs.svh
// Purpose: constants for the bit-serial distributed arithmetic FIR core
// Assumes: one 25 MHz bit clock, APB register access
// Notes:   generation-time choices live here as macros
`ifndef SF_DEFS_SVH
`define SF_DEFS_SVH

// ****************************************************************
// generation-time configuration
// ****************************************************************
`define SF_SAMPLE_W   8
`define SF_COEF_W     8
`define SF_TAPS       6
`define SF_NUM_COEF   3
`define SF_SYMMETRIC  1
`define SF_ANTISYM    0
`define SF_SIGNED     1
`define SF_CASCADE    0
`define SF_TRIM       0
`define SF_FULL_W     18
`define SF_OUT_W      16
`define SF_CNT_W      6

// ****************************************************************
// legal ranges
// ****************************************************************
`define SF_SAMPLE_MIN 4
`define SF_SAMPLE_MAX 32
`define SF_COEF_MIN   4
`define SF_COEF_MAX   24
`define SF_OUT_MIN    2
`define SF_OUT_MAX    31
`define SF_TAPS_MIN   6
`define SF_TAPS_NS_MAX 40
`define SF_TAPS_SY_MAX 80

// ****************************************************************
// look-up table and adder tree latency
// ****************************************************************
`define SF_LAT_NS_T1  10
`define SF_LAT_NS_T2  20
`define SF_LAT_NS_A   3
`define SF_LAT_NS_B   4
`define SF_LAT_NS_C   5
`define SF_LAT_SY_T1  20
`define SF_LAT_SY_T2  40
`define SF_LAT_SY_A   4
`define SF_LAT_SY_B   5
`define SF_LAT_SY_C   6

// ****************************************************************
// register map
// ****************************************************************
`define SF_ADDR_W     8
`define SF_REG_CTRL   8'h00
`define SF_REG_STATUS 8'h04
`define SF_REG_RESULT 8'h08
`define SF_REG_COUNT  8'h0C
`define SF_CTRL_RST   32'h00000000
`define SF_CTRL_MASK  32'h00000001
`define SF_CTRL_SRST  0
`define SF_ST_REQ     0
`define SF_ST_BUSY    1
`define SF_ST_CFG_OK  2
`define SF_ST_SRST    3

`endif

// >>> core/sf_pkg.sv
// Purpose: shared types of the FIR core
// Assumes: sf_defs.svh gives all widths but the 32-bit word and the 2-bit state
// Notes:   types only; the word width and the state codes are their own numbers
`include "sf_defs.svh"

package sf_pkg;

  typedef logic [`SF_SAMPLE_W-1:0] sf_sample_t;
  typedef logic [`SF_OUT_W-1:0]    sf_result_t;
  typedef logic [31:0]             sf_word_t;
  typedef logic [`SF_ADDR_W-1:0]   sf_addr_t;
  typedef logic [`SF_CNT_W-1:0]    sf_cnt_t;

  // sample sequencing: serial bits, then the symmetric extension bit
  typedef enum logic [1:0] {
    SF_IDLE  = 2'b00,
    SF_SHIFT = 2'b01,
    SF_EXT   = 2'b10
  } sf_state_t;

endpackage

// >>> sim/sf_fir_monitor.sv
// Purpose: port-level timing checks of the FIR core
// Assumes: symmetric 8-bit build, 9 cycles a sample, pipeline latency 4
// Notes:   soft reset is mirrored from committed APB writes
`include "sf_defs.svh"

module sf_fir_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire sf_pkg::sf_addr_t   paddr,
  input wire sf_pkg::sf_word_t   pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               sample_strobe,
  input wire logic               sample_request_flag,
  input wire logic               result_valid_flag,
  input wire sf_pkg::sf_result_t filter_output_word
);
  import sf_pkg::*;

  logic srst_q;
  logic take;

  // strobes are ignored while soft reset is set, so track it here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr && paddr == `SF_REG_CTRL) begin
      srst_q <= pwdata[`SF_CTRL_SRST];
    end
  end

  assign take = sample_strobe && sample_request_flag && !srst_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // sample handshake and result timing
  // ****************************************************************
  chk_req_drop: assert property (take |=> !sample_request_flag)
    else $error("request flag high after taken strobe");
  chk_req_return: assert property (take |=> (!sample_request_flag)[*8] ##1
    sample_request_flag)
    else $error("request flag did not return after nine cycles");
  chk_req_idle: assert property (sample_request_flag && !take |=> sample_request_flag)
    else $error("request flag dropped without a strobe");
  chk_valid_time: assert property (take |-> ##13 result_valid_flag)
    else $error("result not valid thirteen cycles after strobe");
  chk_valid_cause: assert property (result_valid_flag |-> $past(take, 13))
    else $error("result valid without a strobe thirteen cycles earlier");
  chk_valid_pulse: assert property (result_valid_flag |=> !result_valid_flag)
    else $error("result valid longer than one cycle");
  chk_word_hold: assert property ($changed(filter_output_word) |-> result_valid_flag)
    else $error("output word changed without valid");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");

  cover property (take ##9 take);
  cover property (result_valid_flag);
  cover property (pslverr);
endmodule // sf_fir_monitor

bind sf_fir_core sf_fir_monitor u_sf_fir_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .sample_strobe(sample_strobe),
  .sample_request_flag(sample_request_flag), .result_valid_flag(result_valid_flag),
  .filter_output_word(filter_output_word));

// >>> sim/sf_src_model.sv
// Purpose: upstream sample source and downstream result sink
// Assumes: one clock shared with the core
// Notes:   idle sample bus toggles so stale data never looks valid
module sf_src_model (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               sample_request_flag,
  input wire logic               result_valid_flag,
  input wire sf_pkg::sf_result_t filter_output_word,
  output logic                   sample_strobe,
  output sf_pkg::sf_sample_t     sample_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import sf_pkg::*;

  sf_sample_t tx_q[$];
  sf_result_t rx_q[$];
  sf_sample_t head_q;
  logic       have_q;

  task push(input sf_sample_t v);
    tx_q.push_back(v);
  endtask

  // strobe only while the core asks, back to back when it can
  assign sample_strobe = have_q && sample_request_flag;
  assign sample_in     = head_q;

  // hold the head sample until taken, then load the next one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_q <= 1'b0;
      head_q <= 8'h00;
    end else if (sample_strobe || !have_q) begin
      if (tx_q.size() != 0) begin
        head_q <= tx_q.pop_front();
        have_q <= 1'b1;
      end else begin
        have_q <= 1'b0;
        head_q <= ~head_q;
      end
    end
  end

  // the word is taken only in the cycle its flag is high
  always @(posedge pclk) begin
    if (presetn && result_valid_flag) begin
      rx_q.push_back(filter_output_word);
    end
  end
endmodule // sf_src_model

// >>> sim/tb_sf_fir_core.sv
// Purpose: self-checking bench of the FIR core
// Assumes: coefficients 1,-8,12,12,-8,1 and two output LSBs dropped
// Notes:   cascade serial inputs are tied low, unused in this build
`include "sf_defs.svh"

module tb_sf_fir_core;
  timeunit 1ns;
  timeprecision 1ns;
  import sf_pkg::*;

  localparam int         COEF [6] = '{1, -8, 12, 12, -8, 1};
  localparam sf_sample_t SMP [8]  = '{8'h80, 8'h7F, 8'h01, 8'hFF, 8'h00, 8'h40, 8'hB3, 8'h05};

  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic       sample_strobe, sample_request_flag, result_valid_flag;
  logic       fwd_out, rev_out, err_seen;
  sf_addr_t   paddr;
  sf_word_t   pwdata, prdata;
  sf_sample_t sample_in;
  sf_result_t filter_output_word;
  int         mismatches, check_count, cyc;
  int         hist [6];

  sf_fir_core u_sf_fir_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_strobe(sample_strobe), .sample_in(sample_in),
    .fwd_serial_in(1'b0), .rev_serial_in(1'b0), .sample_request_flag(sample_request_flag),
    .result_valid_flag(result_valid_flag), .filter_output_word(filter_output_word),
    .fwd_serial_out(fwd_out), .rev_serial_out(rev_out));

  sf_src_model u_sf_src_model (.pclk(pclk), .presetn(presetn),
    .sample_request_flag(sample_request_flag), .result_valid_flag(result_valid_flag),
    .filter_output_word(filter_output_word), .sample_strobe(sample_strobe),
    .sample_in(sample_in));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one APB transfer; request held until ready is sampled high
  // no wait limit here: only the watchdog may end a stuck transfer
  task apb(input logic wr, input sf_addr_t a, input sf_word_t d, output sf_word_t r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r        = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input string name, input sf_addr_t a, input sf_word_t x);
    sf_word_t r;
    apb(1'b0, a, 32'h00000000, r);
    check(name, r, x);
  endtask

  task wait_rx(input int n);
    int k;
    k = 0;
    while (u_sf_src_model.rx_q.size() < n && k < 300) begin
      @(posedge pclk);
      k++;
    end
  endtask

  // mirrored six-tap sum, floored to the top 16 of 18 bits
  function automatic sf_result_t expect_next(input sf_sample_t s);
    int full;
    for (int k = 5; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = signed'(s);
    full = 0;
    for (int k = 0; k < 6; k++) full += COEF[k] * hist[k];
    return sf_result_t'(full >>> 2);
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    sf_word_t r;
    check("request", sample_request_flag, 1);
    check("valid", result_valid_flag, 0);
    rd_chk("ctrl", `SF_REG_CTRL, 32'h00000000);
    rd_chk("status", `SF_REG_STATUS, 32'h00000005);
    apb(1'b1, `SF_REG_STATUS, 32'hFFFFFFFF, r);
    rd_chk("status ro", `SF_REG_STATUS, 32'h00000005);
    rd_chk("count", `SF_REG_COUNT, 32'h00000000);
    apb(1'b0, 8'h10, 32'h00000000, r);
    check("unmapped err", err_seen, 1);
    $display("test reset done");
  endtask

  task t_stream;
    sf_result_t exp;
    u_sf_src_model.rx_q.delete();
    foreach (SMP[i]) u_sf_src_model.push(SMP[i]);
    wait_rx(8);
    check("results", u_sf_src_model.rx_q.size(), 8);
    // idle links show bit 0 of the oldest sample in each delay line
    check("fwd link", fwd_out, SMP[5][0]);
    check("rev link", rev_out, SMP[2][0]);
    for (int i = 0; i < 8; i++) begin
      exp = expect_next(SMP[i]);
      check("word", u_sf_src_model.rx_q[i], exp);
    end
    rd_chk("count", `SF_REG_COUNT, 32'h00000008);
    rd_chk("result", `SF_REG_RESULT, {16'h0000, exp});
    $display("test stream done");
  endtask

  task t_soft;
    sf_word_t r;
    apb(1'b1, `SF_REG_CTRL, 32'h00000001, r);
    rd_chk("status srst", `SF_REG_STATUS, 32'h0000000D);
    u_sf_src_model.rx_q.delete();
    u_sf_src_model.push(8'h33);
    repeat (20) @(posedge pclk);
    check("ignored", u_sf_src_model.rx_q.size(), 0);
    rd_chk("count clr", `SF_REG_COUNT, 32'h00000000);
    apb(1'b1, `SF_REG_CTRL, 32'h00000000, r);
    u_sf_src_model.push(8'h21);
    wait_rx(1);
    check("resumed", u_sf_src_model.rx_q.size(), 1);
    // soft reset keeps the delay lines, and the ignored sample never entered
    check("resumed word", u_sf_src_model.rx_q[0], expect_next(8'h21));
    $display("test soft reset done");
  endtask

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h00000000;
    err_seen = 1'b0;
    foreach (hist[i]) hist[i] = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_stream();
    t_soft();
    conclude();
  end
endmodule // tb_sf_fir_core
